// ---- design/sgio_map.svh ----
// Register offsets, field positions and reset values of the sense and I/O block.
`ifndef SGIO_MAP_SVH
`define SGIO_MAP_SVH

// Bus word offsets.
`define SGIO_A_INDEX 8'h00
`define SGIO_A_DATA 8'h04
`define SGIO_A_ISTAT 8'h08
`define SGIO_A_ICLR 8'h0C
`define SGIO_A_IEN 8'h10

// Configuration indices reached through the data word.
`define SGIO_IX_STATUS 7'h02
`define SGIO_IX_CMD 7'h07
`define SGIO_IX_DIR 7'h58
`define SGIO_IX_POL 7'h59
`define SGIO_IX_SENS 7'h5A
`define SGIO_IX_OUT 7'h5B
`define SGIO_IX_STOP 7'h5C
`define SGIO_IX_DELAY 7'h5D

// Command field positions.
`define SGIO_CMD_SRST_BIT 2
`define SGIO_CMD_ACT_BIT 3

// Status bit positions.
`define SGIO_ST_SENSE1 0
`define SGIO_ST_SENSE2 1
`define SGIO_ST_MISC 2
`define SGIO_IRQ_STOP 8

// Reset values.
`define SGIO_DIR_RST 6'h38
`define SGIO_POL_RST 8'hE3
`define SGIO_SENS_RST 8'h1C
`define SGIO_OUT_RST 6'h18
`define SGIO_STOP_RST 2'h0
`define SGIO_DELAY_RST 8'h00

// Bus responses.
`define SGIO_RESP_OKAY 2'h0
`define SGIO_RESP_SLVERR 2'h2

`endif

// ---- design/sgio_pkg.sv ----
// Types shared by the sense and I/O block.
package sgio_pkg;
  // Motion command; codes follow a Gray order.
  typedef enum logic [1:0] {
    SGIO_IDLE = 2'h0,
    SGIO_SCAN = 2'h1,
    SGIO_FFWD = 2'h3,
    SGIO_FREV = 2'h2
  } sgio_mode_e;
endpackage : sgio_pkg

// ---- design/sgio_top.sv ----
// Sense and general I/O block with an AXI4-Lite register slave.
`include "sgio_map.svh"

module sgio_top
  import sgio_pkg::*;
#(
  parameter int NUM_MISC = 6,
  parameter int LINE_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic usb_suspend,
  input wire logic line_tick,
  input wire logic [1:0] sense_in,
  input wire logic [5:0] misc_in,
  output logic [5:0] misc_out,
  output logic [5:0] misc_oe_n,
  output logic scan_active,
  output logic [1:0] scan_mode,
  output logic soft_reset,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // The register layout is fixed to six configurable pins and an 8-bit delay.
  if (NUM_MISC != 6 || LINE_W != 8) begin : g_chk_param
    $error("sgio_top supports six configurable pins and an 8-bit line delay only.");
  end

  // Write channel state.
  logic aw_hold; // Write address captured.
  logic w_hold; // Write data captured.
  logic [7:0] aw_addr_q; // Captured write address.
  logic [31:0] w_data_q; // Captured write data.
  logic [3:0] w_strb_q; // Captured byte strobes.

  // Configuration state.
  logic [6:0] cfg_index; // Current configuration index.
  logic [7:0] pol; // Polarity per pin.
  logic [7:0] sens; // Sensitivity per pin, 1 is edge.
  logic [1:0] stop_en; // Stop enables for the two sense inputs.
  logic [7:0] line_delay; // Lines from sense two rise to its stop.
  logic [8:0] istat; // Sticky interrupt status.
  logic [8:0] ien; // Interrupt enables.

  // Input path.
  logic [7:0] sync1; // First synchroniser stage.
  logic [7:0] sync2; // Second synchroniser stage.
  logic [7:0] adj_q; // Previous adjusted level.
  logic [7:0] edge_flag; // Latched rising edges.
  logic rep0_q; // Previous reported sense one state.
  logic d2_busy; // Sense two delay running.
  logic [7:0] d2_cnt; // Lines left before sense two acts.
  logic d2_flag; // Sense two delayed status bit.

  // Combinational helpers.
  logic [7:0] pins; // Raw levels, sense inputs in the low bits.
  logic [7:0] adj; // Polarity-adjusted levels.
  logic [7:0] rise; // Adjusted rising edges.
  logic [7:0] status; // Status word as reported.
  logic wr_fire; // A full write is performed this cycle.
  logic wr_lane0; // The write carries its low byte.
  logic wr_data; // Write to the indexed configuration word.
  logic ar_fire; // A read is accepted this cycle.
  logic st_clr; // Status read clears edge bits.
  logic d2_fire; // Sense two delay expires this cycle.
  logic stop1; // Sense one requests a stop.
  logic stop2; // Sense two requests a stop.
  logic idle_ok; // Pin registers may be written.
  logic [7:0] cfg_rd; // Indexed read value.
  logic [31:0] rd_val; // Bus read value.
  logic addr_ok_w; // Write address is mapped.
  logic addr_ok_r; // Read address is mapped.
  logic [8:0] ev; // Interrupt events.

  assign pins = {misc_in, sense_in};
  assign wr_fire = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_lane0 = wr_fire & w_strb_q[0];
  assign wr_data = wr_lane0 & (aw_addr_q == `SGIO_A_DATA);
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign idle_ok = ~scan_active;

  // Two-stage synchroniser on every pin; it runs through reset to hold settled levels.
  always_ff @(posedge clk_sys) begin
    sync1 <= pins;
    sync2 <= sync1;
  end

  // Polarity: a set bit makes high true, a clear bit makes low true.
  assign adj = sync2 ~^ pol;
  assign rise = adj & ~adj_q;

  // Reported status: level bits follow the pin, edge bits are latched.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      status[i] = sens[i] ? edge_flag[i] : adj[i];
    end
    // With its stop enabled, sense two reports the delayed event instead.
    if (stop_en[1]) begin
      status[`SGIO_ST_SENSE2] = d2_flag;
    end
  end

  // Status read through the data word at the status index.
  assign st_clr = ar_fire & (s_axi_araddr == `SGIO_A_DATA)
                  & (cfg_index == `SGIO_IX_STATUS);

  // Edge history and latched edges; a new edge wins over a clearing read.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      adj_q <= adj; // Following the pins in reset keeps a false edge out of release.
      edge_flag <= 8'h00;
      rep0_q <= status[`SGIO_ST_SENSE1];
    end else begin
      adj_q <= adj;
      edge_flag <= (edge_flag & ~{8{st_clr}}) | rise;
      rep0_q <= status[`SGIO_ST_SENSE1];
    end
  end

  // Sense one stops on a rise of its reported state.
  assign stop1 = stop_en[0] & status[`SGIO_ST_SENSE1] & ~rep0_q;
  // Sense two acts at once with a zero delay, else after the counted lines.
  assign d2_fire = stop_en[1] & ((rise[`SGIO_ST_SENSE2] & (line_delay == 8'h00))
                   | (d2_busy & line_tick & (d2_cnt == 8'h01)));
  // Sense two stops only scan and fast advance, never fast return.
  assign stop2 = d2_fire & ((scan_mode == SGIO_SCAN)
                 | (scan_mode == SGIO_FFWD));

  // Line counter for the sense two delay.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      d2_busy <= 1'b0;
      d2_cnt <= 8'h00;
    end else if (soft_reset || !stop_en[1]) begin
      d2_busy <= 1'b0;
      d2_cnt <= 8'h00;
    end else if (rise[`SGIO_ST_SENSE2] && line_delay != 8'h00) begin
      d2_busy <= 1'b1;
      d2_cnt <= line_delay;
    end else if (d2_busy && line_tick) begin
      d2_cnt <= d2_cnt - 8'h01;
      d2_busy <= (d2_cnt != 8'h01);
    end
  end

  // Delayed sense two status bit; a new event wins over a clearing read.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      d2_flag <= 1'b0;
    end else begin
      d2_flag <= (d2_flag & ~st_clr) | d2_fire;
    end
  end

  // Motion command and scan-active flag.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scan_mode <= SGIO_IDLE;
      scan_active <= 1'b0;
      soft_reset <= 1'b0;
    end else if (wr_data && cfg_index == `SGIO_IX_CMD) begin
      // A new command wins over a sensor stop in the same cycle.
      scan_mode <= w_data_q[1:0];
      soft_reset <= w_data_q[`SGIO_CMD_SRST_BIT];
      scan_active <= (w_data_q[1:0] != SGIO_IDLE) & ~w_data_q[`SGIO_CMD_SRST_BIT];
    end else if (scan_active && (stop1 || stop2)) begin
      scan_active <= 1'b0;
      scan_mode <= SGIO_IDLE;
    end
  end

  // Pin setup; reset by the reset pin or suspend, never by soft reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || usb_suspend) begin
      misc_oe_n <= ~`SGIO_DIR_RST;
      misc_out <= `SGIO_OUT_RST;
      pol <= `SGIO_POL_RST;
      sens <= `SGIO_SENS_RST;
    end else if (wr_data && idle_ok) begin
      // Direction 1 drives the pin, so the enable is its inverse.
      if (cfg_index == `SGIO_IX_DIR) begin
        misc_oe_n <= ~w_data_q[5:0];
      end
      if (cfg_index == `SGIO_IX_OUT) begin
        misc_out <= w_data_q[5:0];
      end
      if (cfg_index == `SGIO_IX_POL) begin
        pol <= w_data_q[7:0];
      end
      if (cfg_index == `SGIO_IX_SENS) begin
        sens <= w_data_q[7:0];
      end
    end
  end

  // Stop controls accept writes only in soft reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stop_en <= `SGIO_STOP_RST;
      line_delay <= `SGIO_DELAY_RST;
    end else if (wr_data && soft_reset) begin
      if (cfg_index == `SGIO_IX_STOP) begin
        stop_en <= w_data_q[1:0];
      end
      if (cfg_index == `SGIO_IX_DELAY) begin
        line_delay <= w_data_q[7:0];
      end
    end
  end

  // Index register; it holds until rewritten.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_index <= 7'h00;
    end else if (wr_lane0 && aw_addr_q == `SGIO_A_INDEX) begin
      cfg_index <= w_data_q[6:0];
    end
  end

  // Interrupt events: pin rises and a sensor stop.
  assign ev = {scan_active & (stop1 | stop2), rise};

  // Sticky interrupt status; a new event wins over a clear.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      istat <= 9'h000;
    end else if (wr_fire && aw_addr_q == `SGIO_A_ICLR) begin
      istat <= (istat & ~(w_data_q[8:0] & {{1{w_strb_q[1]}}, {8{w_strb_q[0]}}})) | ev;
    end else begin
      istat <= istat | ev;
    end
  end

  // Interrupt enables.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ien <= 9'h000;
    end else if (wr_fire && aw_addr_q == `SGIO_A_IEN) begin
      // Byte lane 0 carries bits 7:0 and lane 1 carries bit 8.
      ien <= {w_strb_q[1] ? w_data_q[8] : ien[8], w_strb_q[0] ? w_data_q[7:0] : ien[7:0]};
    end
  end

  // Interrupt output, high while an enabled status bit is set.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & ien);
    end
  end

  // Address maps of the bus.
  assign addr_ok_w = (aw_addr_q == `SGIO_A_INDEX) | (aw_addr_q == `SGIO_A_DATA)
                     | (aw_addr_q == `SGIO_A_ISTAT) | (aw_addr_q == `SGIO_A_ICLR)
                     | (aw_addr_q == `SGIO_A_IEN);
  assign addr_ok_r = (s_axi_araddr == `SGIO_A_INDEX) | (s_axi_araddr == `SGIO_A_DATA)
                     | (s_axi_araddr == `SGIO_A_ISTAT) | (s_axi_araddr == `SGIO_A_ICLR)
                     | (s_axi_araddr == `SGIO_A_IEN);

  // Indexed configuration read; unknown indices read zero.
  always_comb begin
    cfg_rd = 8'h00;
    unique case (cfg_index)
      `SGIO_IX_STATUS: cfg_rd = status;
      `SGIO_IX_CMD: cfg_rd = {4'h0, scan_active, soft_reset, scan_mode};
      `SGIO_IX_DIR: cfg_rd = {2'h0, ~misc_oe_n};
      `SGIO_IX_POL: cfg_rd = pol;
      `SGIO_IX_SENS: cfg_rd = sens;
      `SGIO_IX_OUT: cfg_rd = {2'h0, misc_out};
      `SGIO_IX_STOP: cfg_rd = {6'h00, stop_en};
      `SGIO_IX_DELAY: cfg_rd = line_delay;
      default: cfg_rd = 8'h00;
    endcase
  end

  // Bus read value; the clear register reads zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `SGIO_A_INDEX: rd_val = {25'h0000000, cfg_index};
      `SGIO_A_DATA: rd_val = {24'h000000, cfg_rd};
      `SGIO_A_ISTAT: rd_val = {23'h000000, istat};
      `SGIO_A_IEN: rd_val = {23'h000000, ien};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Write address channel, one write at a time.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      aw_hold <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_hold <= 1'b0;
    end else if (!aw_hold && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, taken in either order with the address.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b0;
      w_hold <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_hold <= 1'b0;
    end else if (!w_hold && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response once both halves are held.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SGIO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok_w ? `SGIO_RESP_OKAY : `SGIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data is captured at acceptance and held until taken.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SGIO_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= addr_ok_r ? `SGIO_RESP_OKAY : `SGIO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sgio_top

// ---- sim/sgio_top_checker.sv ----
// Concurrent checks on the ports of the sense and I/O block.
`include "sgio_map.svh"
module sgio_top_checker #(
  parameter int NUM_MISC = 6,
  parameter int LINE_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic usb_suspend,
  input wire logic [5:0] misc_out,
  input wire logic [5:0] misc_oe_n,
  input wire logic scan_active,
  input wire logic [1:0] scan_mode,
  input wire logic soft_reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks run on the system clock and sleep during reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Address and data taken together are answered two edges later.
  a_write_resp_time: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |=> ##1 s_axi_bvalid) else $error("write answer not on time");
  a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not on time");
  a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  a_read_busy_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  // Suspend forces the pin setup back to its defaults.
  a_suspend_pin_dflt: assert property (usb_suspend |=> misc_oe_n == ~`SGIO_DIR_RST
    && misc_out == `SGIO_OUT_RST) else $error("pins not at defaults in suspend");
  a_active_has_mode: assert property (scan_active |-> scan_mode != 2'h0 && !soft_reset)
    else $error("scan active without a command");
  // Pin setup may not move while a command runs.
  a_pins_frozen_scan: assert property (scan_active && !usb_suspend |=>
    $stable(misc_oe_n) && $stable(misc_out)) else $error("pin setup changed in scan");
endmodule : sgio_top_checker

bind sgio_top sgio_top_checker #(.NUM_MISC(NUM_MISC), .LINE_W(LINE_W)) u_chk (.clk_sys,
  .rst_n, .usb_suspend, .misc_out, .misc_oe_n, .scan_active, .scan_mode, .soft_reset,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready);

// ---- sim/sgio_pads.sv ----
// Sensors, buttons and indicators wired to the pins of the sense and I/O block.
module sgio_pads (
  input wire logic [5:0] misc_out,
  input wire logic [5:0] misc_oe_n,
  input wire logic [5:0] press,
  input wire logic [1:0] sense_lvl,
  output logic [5:0] misc_in,
  output logic [1:0] sense_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released button leaves its pull-up high; a driven pin shows the block's level.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      misc_in[i] = !misc_oe_n[i] ? misc_out[i] : !press[i];
    end
    sense_in = sense_lvl;
  end
endmodule : sgio_pads

// ---- sim/tb.sv ----
// Self-checking bench for the sense and I/O block.
`include "sgio_map.svh"
module tb import sgio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_n = 0, usb_suspend = 0, line_tick = 0;
  logic [1:0] sense_in, scan_mode, s_axi_bresp, s_axi_rresp, rs_v, sense_lvl = 0;
  logic [5:0] misc_in, misc_out, misc_oe_n, press = 0;
  logic scan_active, soft_reset, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v, v, e;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] dflt [4] = '{32'h38, 32'hE3, 32'h1C, 32'h18};
  sgio_mode_e md [3] = '{SGIO_SCAN, SGIO_FFWD, SGIO_FREV};
  int fails = 0, tests_run = 0;
  // The 125 MHz system clock.
  always #4 clk_sys = ~clk_sys;
  sgio_top #(.NUM_MISC(6), .LINE_W(8)) uut (.clk_sys, .rst_n, .usb_suspend, .line_tick,
    .sense_in, .misc_in, .misc_out, .misc_oe_n, .scan_active, .scan_mode, .soft_reset,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  sgio_pads pads (.misc_out, .misc_oe_n, .press, .sense_lvl, .misc_in, .sense_in);
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
      fails++;
    end
  endtask : chk
  // A wait that ran out ends the run as a mismatch.
  task automatic hang(input string nm);
    $display("unexpected %s: expected done seen timeout", nm);
    fails++;
    end_sim();
  endtask : hang
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  // Bus write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    rs_v = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) hang("write");
  endtask : wr
  // Bus read: the answer is taken at the edge that sees rvalid.
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    rd_v = s_axi_rdata;
    rs_v = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) hang("read");
  endtask : rd
  // Indexed configuration access: index first, then the data word.
  task automatic cw(input logic [6:0] ix, input logic [7:0] d);
    wr(`SGIO_A_INDEX, {25'h0, ix});
    wr(`SGIO_A_DATA, {24'h0, d});
  endtask : cw
  task automatic cr(input logic [6:0] ix);
    wr(`SGIO_A_INDEX, {25'h0, ix});
    rd(`SGIO_A_DATA);
  endtask : cr
  task automatic tick;
    @(posedge clk_sys);
    line_tick <= 1'b1;
    @(posedge clk_sys);
    line_tick <= 1'b0;
    cyc(3);
  endtask : tick
  task automatic till_idle;
    int n;
    n = 0;
    while (scan_active !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (scan_active !== 1'b0) hang("stop");
  endtask : till_idle
  // Status expected from pin levels and polarity in level mode.
  function automatic logic [31:0] lvl(input logic [7:0] pins, input logic [7:0] pol);
    return {24'h0, ~(pins ^ pol)};
  endfunction : lvl
  initial begin : main
    void'($urandom(62518));
    cyc(4);
    rst_n <= 1'b1;
    cyc(2);
    chk("oe_n", 32'h07, 32'(misc_oe_n));
    for (int i = 0; i < 4; i++) begin
      cr(7'h58 + 7'(i));
      chk("pin setup", dflt[i], rd_v);
    end
    rd(8'h40);
    chk("unmapped", 32'h2, {30'h0, rs_v});
    wr(8'h44, 32'h1);
    chk("unmapped", 32'h2, {30'h0, rs_v});
    // Falling edge on pin one: interrupt, mask, clear, then status clear on read.
    wr(`SGIO_A_IEN, 32'h4);
    press[0] <= 1'b1;
    cyc(5);
    chk("irq", 1, 32'(irq));
    rd(`SGIO_A_ISTAT);
    chk("istat", 1, 32'(rd_v[2]));
    wr(`SGIO_A_IEN, 32'h0);
    cyc(2);
    chk("irq", 0, 32'(irq));
    wr(`SGIO_A_IEN, 32'h4);
    cyc(2);
    chk("irq", 1, 32'(irq));
    wr(`SGIO_A_ICLR, 32'h4);
    cyc(2);
    chk("irq", 0, 32'(irq));
    cr(`SGIO_IX_STATUS);
    chk("status", 32'h64, rd_v);
    rd(`SGIO_A_DATA);
    chk("status", 32'h60, rd_v);
    // Pins two and three fall too; pin one stays low and adds no new edge.
    press <= 6'h07;
    cyc(5);
    cr(`SGIO_IX_STATUS);
    chk("status", 32'h78, rd_v);
    press[0] <= 1'b0;
    cw(`SGIO_IX_DIR, 8'h00);
    cw(`SGIO_IX_SENS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      if (i < 2) v[7:0] = {8{i[0]}};
      cw(`SGIO_IX_POL, v[7:0]);
      press <= v[13:8];
      sense_lvl <= v[15:14];
      cyc(4);
      e = lvl({~v[13:8], v[15:14]}, v[7:0]);
      cr(`SGIO_IX_STATUS);
      chk("level status", e, rd_v);
      rd(`SGIO_A_DATA);
      chk("level status", e, rd_v);
    end
    press <= 6'h00;
    sense_lvl <= 2'h0;
    cw(`SGIO_IX_POL, 8'hFF);
    cw(`SGIO_IX_DIR, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      cw(`SGIO_IX_OUT, v[7:0]);
      cyc(4);
      chk("oe_n", 0, 32'(misc_oe_n));
      chk("out", {26'h0, v[5:0]}, 32'(misc_out));
      cr(`SGIO_IX_STATUS);
      chk("out status", {24'h0, v[5:0], 2'h0}, rd_v);
    end
    cw(`SGIO_IX_CMD, 8'h04);
    chk("soft reset", 1, 32'(soft_reset));
    chk("out", {26'h0, v[5:0]}, 32'(misc_out));
    cw(`SGIO_IX_STOP, 8'h03);
    cw(`SGIO_IX_DELAY, 8'h02);
    cw(`SGIO_IX_CMD, 8'h00);
    for (int m = 0; m < 3; m++) begin
      cw(`SGIO_IX_CMD, {6'h0, md[m]});
      chk("active", 1, 32'(scan_active));
      chk("mode", 32'(md[m]), 32'(scan_mode));
      cw(`SGIO_IX_OUT, ~v[7:0]);
      chk("out", {26'h0, v[5:0]}, 32'(misc_out));
      sense_lvl[0] <= 1'b1;
      till_idle();
      chk("mode", 0, 32'(scan_mode));
      sense_lvl[0] <= 1'b0;
      cyc(4);
    end
    cw(`SGIO_IX_CMD, {6'h0, SGIO_FREV});
    sense_lvl[1] <= 1'b1;
    cyc(4);
    repeat (3) tick();
    chk("active", 1, 32'(scan_active));
    sense_lvl[1] <= 1'b0;
    cyc(4);
    wr(`SGIO_A_ICLR, 32'h100);
    rd(`SGIO_A_ISTAT);
    chk("stop event", 0, 32'(rd_v[8]));
    cw(`SGIO_IX_CMD, {6'h0, SGIO_SCAN});
    cr(`SGIO_IX_STATUS);
    sense_lvl[1] <= 1'b1;
    cyc(4);
    tick();
    chk("active", 1, 32'(scan_active));
    tick();
    till_idle();
    cr(`SGIO_IX_STATUS);
    chk("sense two", 1, 32'(rd_v[1]));
    rd(`SGIO_A_ISTAT);
    chk("stop event", 1, 32'(rd_v[8]));
    usb_suspend <= 1'b1;
    cyc(3);
    chk("oe_n", 32'h07, 32'(misc_oe_n));
    chk("out", 32'h18, 32'(misc_out));
    usb_suspend <= 1'b0;
    cyc(2);
    cr(`SGIO_IX_DIR);
    chk("dir", 32'h38, rd_v);
    end_sim();
  end
endmodule : tb
